// [ccms_clock_select.sv]
// CPU clock mode selection, prescaler, PLL model and oscillator watchdog
// Notes on behaviour
// - Clock mechanism chosen by three pins at reset
// - Codes select PLL factors 4,3,2,5,1.5,2.5
// - Code 001 divides the input clock by two
// - Prescaler phases each last one input period
// - PLL runs in PLL modes; in codes 011 and 001 unless watchdog disable bit set
// - Marks every CPU clock edge as timing unit
// - Code 011 drives CPU clock directly, PLL off only when watchdog disabled
// - Watchdog enabled after reset in codes 011 and 001; config bit 4 disables
// - Counter cleared on input transitions, overflows at 16
// - Overflow: switch to free-run, flag irq, latch
`timescale 1ns/1ps
module ccms_clock_select #(
  parameter int PERIOD_W = 16 // Width of the input period measurement
) (
  input wire logic i_mclk, // Free-running reference clock, 125 MHz
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_ext_clock_input, // External clock pin
  input wire logic [2:0] i_reset_clock_mode_pins, // Mode pins, sampled at reset
  input wire logic [7:0] i_system_config_reg, // System configuration word
  output logic o_cpu_clk, // Generated CPU clock
  output logic o_cpu_edge, // One-cycle pulse on each CPU clock edge
  output logic o_clock_fail_irq, // Sticky clock failure request
  output ccms_pkg::ccms_status_t o_status // Mode and source status
);
  import ccms_pkg::*;

  // The reference clock stands in for the free-running PLL; a real part would
  // run its PLL from its own oscillator, so fallback timing here is idealised.

  // Pin synchronisers: three stages, change counted when stages two and three agree
  logic [2:0] ext_sync_q;
  logic [2:0] mode_s1_q;
  logic [2:0] mode_s2_q;
  logic [2:0] mode_s3_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_sync_q <= 3'h0;
      mode_s1_q <= 3'h0;
      mode_s2_q <= 3'h0;
      mode_s3_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], i_ext_clock_input};
      mode_s1_q <= i_reset_clock_mode_pins;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
    end
  end

  // Filtered input level and its transitions. The synchroniser starts from zero, so a pin
  // idling high would look like a rising edge right after reset; transitions only count
  // once the stages hold real pin samples, which keeps prescaler and period counter honest.
  logic ext_lvl_q;
  logic ext_lvl_d;
  logic ext_primed_q;
  wire ext_agree = (ext_sync_q[1] == ext_sync_q[2]);
  assign ext_lvl_d = ext_agree ? ext_sync_q[2] : ext_lvl_q;
  wire ext_toggle = ext_primed_q && (ext_lvl_d != ext_lvl_q);
  wire ext_rise = ext_toggle & ext_lvl_d;

  // Mode capture a few cycles after release so the synchroniser has settled
  // Pins that disagree at capture fall back to the default factor of four
  logic [1:0] cap_cnt_q;
  logic cap_done_q;
  logic [2:0] mode_q;
  wire cap_now = !cap_done_q && (cap_cnt_q == CCMS_CAPTURE_WAIT);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
      mode_q <= CCMS_MODE_X4;
    end else if (cap_now) begin
      cap_done_q <= 1'b1;
      mode_q <= (mode_s2_q == mode_s3_q) ? mode_s3_q : CCMS_MODE_X4;
    end else if (!cap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
    end
  end

  // Transitions count only once the synchroniser holds real samples of the pin
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_primed_q <= 1'b0;
    end else begin
      ext_primed_q <= (cap_cnt_q == CCMS_CAPTURE_WAIT);
    end
  end

  // Edges per input period for each PLL code
  // Unlisted codes give eight, the factor-four reset default
  function automatic logic [3:0] ccms_edges(input logic [2:0] code);
    case (code)
      CCMS_MODE_X3: ccms_edges = CCMS_EDGES_X3;
      CCMS_MODE_X2: ccms_edges = CCMS_EDGES_X2;
      CCMS_MODE_X5: ccms_edges = CCMS_EDGES_X5;
      CCMS_MODE_X1P5: ccms_edges = CCMS_EDGES_X1P5;
      CCMS_MODE_X2P5: ccms_edges = CCMS_EDGES_X2P5;
      default: ccms_edges = CCMS_EDGES_X4;
    endcase
  endfunction : ccms_edges

  // Source decode
  // Watchdog exists only for the two non-PLL codes; PLL modes need no fallback
  wire is_direct = cap_done_q && (mode_q == CCMS_MODE_DIRECT);
  wire is_prescale = cap_done_q && (mode_q == CCMS_MODE_PRESCALE);
  wire is_pll = cap_done_q && !is_direct && !is_prescale;
  wire wdog_dis = i_system_config_reg[CCMS_SYSCFG_WDOG_DIS_BIT];
  wire wdog_on = (is_direct || is_prescale) && !wdog_dis;
  wire [3:0] edges = ccms_edges(mode_q);

  // Oscillator watchdog: the reference clock stands in for the free-running PLL
  logic [4:0] wdog_cnt_q;
  logic fail_q;
  wire wdog_ovf = wdog_on && !ext_toggle && (wdog_cnt_q == CCMS_WDOG_LIMIT - 5'h1);

  // Watchdog counter: zero while idle or on a transition, frozen after a failure
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wdog_cnt_q <= 5'h0;
    end else if (!wdog_on || ext_toggle) begin
      wdog_cnt_q <= 5'h0;
    end else if (!fail_q) begin
      wdog_cnt_q <= wdog_cnt_q + 5'h1;
    end
  end

  // Failure latch: only a hardware reset brings the input clock back as source
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fail_q <= 1'b0;
    end else if (wdog_ovf) begin
      fail_q <= 1'b1;
    end
  end

  // Input period measurement between rising edges, saturating on a stall
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] period_q;
  logic per_armed_q;
  wire per_max = &per_cnt_q;
  // The first rise after reset only starts the count; a partial period would mistune the PLL
  wire per_load = ext_rise && per_armed_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      per_cnt_q <= '0;
      period_q <= '0;
      per_armed_q <= 1'b0;
    end else begin
      if (ext_rise) begin
        per_armed_q <= 1'b1;
        per_cnt_q <= '0;
      end else if (!per_max) begin
        per_cnt_q <= per_cnt_q + PERIOD_W'(1);
      end
      if (per_load) begin
        period_q <= per_cnt_q + PERIOD_W'(1);
      end
    end
  end

  // PLL model: phase accumulator yields 'edges' CPU edges per input period.
  // Input periods shorter than the edge count per period drop CPU edges.
  // Edge placement jitters by one reference cycle, like a real PLL's jitter.
  logic [PERIOD_W:0] acc_q;
  wire [PERIOD_W:0] acc_sum = acc_q + {{(PERIOD_W-3){1'b0}}, edges};
  wire pll_hit = (period_q != '0) && (acc_sum >= {1'b0, period_q});
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= '0;
    end else if (!is_pll || period_q == '0) begin
      acc_q <= '0;
    end else if (pll_hit) begin
      acc_q <= acc_sum - {1'b0, period_q};
    end else begin
      acc_q <= acc_sum;
    end
  end

  // Next CPU clock level per source; after a failure the free-run wins
  wire clk_free = !o_cpu_clk;
  wire clk_prescale = ext_rise ? !o_cpu_clk : o_cpu_clk;
  wire clk_pll = (is_pll && pll_hit) ? !o_cpu_clk : o_cpu_clk;
  logic cpu_clk_d;
  ccms_src_t src_d;
  assign cpu_clk_d = fail_q ? clk_free
    : is_direct ? ext_lvl_d
    : is_prescale ? clk_prescale
    : clk_pll;
  assign src_d = fail_q ? CCMS_SRC_FREERUN
    : is_direct ? CCMS_SRC_DIRECT
    : is_prescale ? CCMS_SRC_PRESCALE
    : CCMS_SRC_PLL;

  // CPU clock and its edge marker
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_lvl_q <= 1'b0;
      o_cpu_clk <= 1'b0;
      o_cpu_edge <= 1'b0;
    end else begin
      ext_lvl_q <= ext_lvl_d;
      o_cpu_clk <= cpu_clk_d;
      o_cpu_edge <= (cpu_clk_d != o_cpu_clk);
    end
  end

  // Failure request and status word
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_clock_fail_irq <= 1'b0;
      o_status <= '0;
    end else begin
      o_clock_fail_irq <= fail_q | wdog_ovf;
      o_status.mode_valid <= cap_done_q;
      o_status.mode <= mode_q;
      o_status.src <= src_d;
      o_status.pll_on <= is_pll || fail_q || wdog_on;
      o_status.clock_fail <= fail_q;
    end
  end

endmodule : ccms_clock_select

// [ccms_pkg.sv]
// Constants and types for the CPU clock mode selector
package ccms_pkg;

  // Reset-time mode codes on the three configuration bits
  localparam logic [2:0] CCMS_MODE_X4 = 3'h7;
  localparam logic [2:0] CCMS_MODE_X3 = 3'h6;
  localparam logic [2:0] CCMS_MODE_X2 = 3'h5;
  localparam logic [2:0] CCMS_MODE_X5 = 3'h4;
  localparam logic [2:0] CCMS_MODE_DIRECT = 3'h3;
  localparam logic [2:0] CCMS_MODE_X1P5 = 3'h2;
  localparam logic [2:0] CCMS_MODE_PRESCALE = 3'h1;
  localparam logic [2:0] CCMS_MODE_X2P5 = 3'h0;

  // CPU clock edges per input clock period (twice the factor)
  localparam logic [3:0] CCMS_EDGES_X4 = 4'h8;
  localparam logic [3:0] CCMS_EDGES_X3 = 4'h6;
  localparam logic [3:0] CCMS_EDGES_X2 = 4'h4;
  localparam logic [3:0] CCMS_EDGES_X5 = 4'ha;
  localparam logic [3:0] CCMS_EDGES_X1P5 = 4'h3;
  localparam logic [3:0] CCMS_EDGES_X2P5 = 4'h5;

  // Watchdog overflow after this many free-running clock cycles
  localparam logic [4:0] CCMS_WDOG_LIMIT = 5'h10;
  // Bit of the system configuration word that disables the watchdog
  localparam int CCMS_SYSCFG_WDOG_DIS_BIT = 4;
  // Cycles after reset release before the mode pins are captured
  localparam logic [1:0] CCMS_CAPTURE_WAIT = 2'h3;

  // How the CPU clock is currently produced
  typedef enum logic [1:0] {
    CCMS_SRC_PLL,
    CCMS_SRC_DIRECT,
    CCMS_SRC_PRESCALE,
    CCMS_SRC_FREERUN
  } ccms_src_t;

  // Status carried out of the block
  typedef struct packed {
    logic mode_valid;
    logic [2:0] mode;
    ccms_src_t src;
    logic pll_on;
    logic clock_fail;
  } ccms_status_t;

endpackage : ccms_pkg

// [ccms_monitor.sv]
// Port checker for the CPU clock mode selector
`timescale 1ns/1ps
module ccms_monitor (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Reset
  input wire logic [2:0] i_reset_clock_mode_pins, // Mode pins
  input wire logic [7:0] i_system_config_reg, // Config word
  input wire logic o_cpu_clk, // CPU clock
  input wire logic o_cpu_edge, // Edge pulse
  input wire logic o_clock_fail_irq, // Failure request
  input wire ccms_pkg::ccms_status_t o_status // Status
);
  import ccms_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Watchdog only exists for the two non-PLL codes
  wire logic wd_mode = (o_status.mode == CCMS_MODE_DIRECT)
    || (o_status.mode == CCMS_MODE_PRESCALE);
  wire logic cfg_off = i_system_config_reg[CCMS_SYSCFG_WDOG_DIS_BIT];
  property p_edge; o_cpu_edge == $changed(o_cpu_clk); endproperty
  a_edge: assert property (p_edge) else $error("edge pulse wrong");
  property p_sticky; o_clock_fail_irq |=> o_clock_fail_irq; endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped");
  property p_flag; $rose(o_clock_fail_irq) |-> ##[1:2] (o_status.clock_fail
    && o_status.src == CCMS_SRC_FREERUN); endproperty
  a_flag: assert property (p_flag) else $error("no switch to free run");
  property p_free; o_status.clock_fail |=> $changed(o_cpu_clk); endproperty
  a_free: assert property (p_free) else $error("free run clock stalled");
  property p_hold; o_status.mode_valid |=> o_status.mode_valid
    && $stable(o_status.mode); endproperty
  a_hold: assert property (p_hold) else $error("mode changed");
  property p_idle; !o_status.mode_valid |-> !o_cpu_clk; endproperty
  a_idle: assert property (p_idle) else $error("clock before capture");
  property p_cap; $rose(o_status.mode_valid)
    |-> o_status.mode == $past(i_reset_clock_mode_pins, 2); endproperty
  a_cap: assert property (p_cap) else $error("wrong captured mode");
  property p_wd; $rose(o_clock_fail_irq) |-> wd_mode && !$past(cfg_off); endproperty
  a_wd: assert property (p_wd) else $error("watchdog fired while idle");
  property p_off; o_status.mode_valid && o_status.mode == CCMS_MODE_DIRECT && cfg_off
    && $past(cfg_off, 2) && !o_status.clock_fail |-> !o_status.pll_on; endproperty
  a_off: assert property (p_off) else $error("pll not off");
  property p_pll; o_status.mode_valid && !wd_mode |-> o_status.pll_on
    && o_status.src == CCMS_SRC_PLL; endproperty
  a_pll: assert property (p_pll) else $error("pll mode source wrong");
  c_fail: cover property ($rose(o_clock_fail_irq));
  c_pre: cover property (o_status.src == CCMS_SRC_PRESCALE && o_cpu_edge);
  c_dir: cover property (o_status.src == CCMS_SRC_DIRECT && o_cpu_edge);
endmodule : ccms_monitor
bind ccms_clock_select ccms_monitor ccms_monitor_i (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_reset_clock_mode_pins(i_reset_clock_mode_pins), .i_system_config_reg(i_system_config_reg),
  .o_cpu_clk(o_cpu_clk), .o_cpu_edge(o_cpu_edge), .o_clock_fail_irq(o_clock_fail_irq),
  .o_status(o_status));

// [ccms_xtal_model.sv]
// Model of the external clock source on the clock pin
`timescale 1ns/1ps
module ccms_xtal_model (
  input wire logic i_mclk, // Bench clock
  input wire logic i_run, // Oscillate while high
  input wire logic [7:0] i_half, // Half period in mclk cycles
  output logic o_clk = 1'b0 // Clock pin level
);
  logic [7:0] cnt_q = 8'h00;
  // A dead crystal just stops, so the pin keeps its last level
  always @(posedge i_mclk) begin
    cnt_q <= (!i_run || cnt_q >= i_half - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    if (i_run && cnt_q >= i_half - 8'h01) o_clk <= !o_clk;
  end
endmodule : ccms_xtal_model

// [ccms_clock_select_tb.sv]
// Self-checking bench for the CPU clock mode selector
`timescale 1ns/1ps
module ccms_clock_select_tb;
  import ccms_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, run = 1'b0, xclk, cpu_clk, cpu_edge, irq;
  logic [2:0] pins = 3'h7;
  logic [7:0] cfg = 8'h00, half = 8'h04;
  logic [15:0] k;
  ccms_status_t st;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  always #4 mclk = ~mclk;
  ccms_xtal_model ccms_xtal_model_i (.i_mclk(mclk), .i_run(run), .i_half(half), .o_clk(xclk));
  ccms_clock_select ccms_clock_select_i (.i_mclk(mclk), .i_rst(rst), .i_ext_clock_input(xclk),
    .i_reset_clock_mode_pins(pins), .i_system_config_reg(cfg), .o_cpu_clk(cpu_clk),
    .o_cpu_edge(cpu_edge), .o_clock_fail_irq(irq), .o_status(st));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // The mode is only taken at reset, so every scenario reboots
  task automatic boot(input logic [2:0] m, input logic [7:0] c, input logic [7:0] h);
    @(posedge mclk);
    {rst, pins, cfg, half, run} <= {1'b1, m, c, h, 1'b1};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (60) @(posedge mclk);
  endtask : boot
  // Counts CPU clock edges over n cycles, sampled clear of the edge
  task automatic count(input int n);
    k = 16'h0000;
    repeat (n) begin
      @(posedge mclk);
      #1 k = k + {15'h0000, cpu_edge};
    end
  endtask : count
  // Cycles between two CPU clock edges, sampled clear of the edge
  task automatic gap;
    k = 16'h0000;
    do begin
      @(posedge mclk);
      #1;
    end while (!cpu_edge);
    do begin
      @(posedge mclk);
      #1 k = k + 16'h0001;
    end while (!cpu_edge);
  endtask : gap
  // Input gaps of 16 cycles keep the watchdog quiet, 17 trip it
  task automatic t_direct;
    boot(CCMS_MODE_DIRECT, 8'h00, 8'h10);
    repeat (100) @(posedge mclk);
    #1 chk("irq_slow", {15'h0000, irq}, 16'h0000);
    boot(CCMS_MODE_DIRECT, 8'h00, 8'h11);
    repeat (100) @(posedge mclk);
    #1 chk("irq_gap", {15'h0000, irq}, 16'h0001);
    boot(CCMS_MODE_DIRECT, 8'h10, 8'h04);
    count(64);
    chk("dir_edges", {15'h0000, k >= 16'h000f && k <= 16'h0011}, 16'h0001);
    gap();
    chk("dir_phase", k, 16'h0004);
    chk("dir_src", {14'h0000, st.src}, {14'h0000, CCMS_SRC_DIRECT});
    chk("dir_pll", {15'h0000, st.pll_on}, 16'h0000);
    run <= 1'b0;
    repeat (40) @(posedge mclk);
    #1 chk("irq_off", {15'h0000, irq}, 16'h0000);
  endtask : t_direct
  task automatic t_pre;
    boot(CCMS_MODE_PRESCALE, 8'h00, 8'h04);
    count(64);
    chk("pre_edges", {15'h0000, k >= 16'h0007 && k <= 16'h0009}, 16'h0001);
    gap();
    chk("pre_phase", k, 16'h0008);
    chk("pre_pll", {15'h0000, st.pll_on}, 16'h0001);
    run <= 1'b0;
    repeat (40) @(posedge mclk);
    #1 chk("irq_fail", {15'h0000, irq}, 16'h0001);
    run <= 1'b1;
    count(20);
    chk("free_edges", k, 16'h0014);
    chk("free_src", {14'h0000, st.src}, {14'h0000, CCMS_SRC_FREERUN});
  endtask : t_pre
  task automatic t_pll;
    logic [2:0] cd [6] = '{CCMS_MODE_X4, CCMS_MODE_X3, CCMS_MODE_X2, CCMS_MODE_X5,
      CCMS_MODE_X1P5, CCMS_MODE_X2P5};
    logic [3:0] ed [6] = '{CCMS_EDGES_X4, CCMS_EDGES_X3, CCMS_EDGES_X2, CCMS_EDGES_X5,
      CCMS_EDGES_X1P5, CCMS_EDGES_X2P5};
    for (int i = 0; i < 6; i++) begin
      boot(cd[i], 8'h00, 8'h0a);
      count(80);
      chk("pll_edges", {15'h0000, k + 16'h0002 >= 16'(ed[i]) * 4
        && k <= 16'(ed[i]) * 4 + 16'h0002}, 16'h0001);
      chk("pll_mode", {10'h000, st.mode_valid, st.mode, st.src},
        {10'h000, 1'b1, cd[i], CCMS_SRC_PLL});
    end
  endtask : t_pll
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Cuts a hang short well beyond the expected run of about 1600 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    t_direct();
    t_pre();
    t_pll();
    final_report();
  end
endmodule : ccms_clock_select_tb
